// ### design/pte4k_pkg.sv
// Constants, field positions and carrier types for the 4-KByte leaf entry decoder.
// Assumes a 64-bit entry and a fixed host address width.
package pte4k_pkg;

  // Host address width; the reserved field runs from bit 51 down to it
  localparam int HOST_ADDRESS_WIDTH = 48;
  localparam int PAGE_SHIFT         = 12;
  localparam int ADDR_TOP           = 51;
  localparam int PAGE_ADDR_W        = HOST_ADDRESS_WIDTH - PAGE_SHIFT;

  // Field positions inside the entry
  localparam int EXECUTE_DISABLE_BIT   = 63;
  localparam int IGN_HI_TOP            = 62;
  localparam int IGN_HI_BOT            = 52;
  localparam int IGN_11_BIT            = 11;
  localparam int EXTENDED_ACCESSED_BIT = 10;
  localparam int IGN_9_BIT             = 9;
  localparam int GLOBAL_BIT            = 8;
  localparam int PAGE_ATTRIBUTE_BIT    = 7;
  localparam int DIRTY_BIT             = 6;
  localparam int ACCESSED_BIT          = 5;
  localparam int CACHE_DISABLE_BIT     = 4;
  localparam int WRITE_THROUGH_BIT     = 3;
  localparam int USER_BIT              = 2;
  localparam int READ_WRITE_BIT        = 1;
  localparam int PRESENT_BIT           = 0;

  // Translation-type field value meaning nested translation
  localparam logic [2:0] TT_NESTED = 3'h3;

  localparam logic [63:0] ENTRY_RESET = 64'h0;
  localparam logic [2:0]  MEMTYPE_RESET = 3'h0;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_NOT_PRESENT,
    CAUSE_RESERVED,
    CAUSE_USER,
    CAUSE_WRITE,
    CAUSE_EXECUTE
  } fault_cause_e;

  typedef struct packed {
    logic [63:0] entry;
    logic        user;
    logic        write;
    logic        exec;
  } req_s;

  typedef struct packed {
    logic       no_execute_enable;
    logic       write_protect_enable;
    logic       extended_access_flag_enable;
    logic [2:0] translation_type_field;
    logic       coherent;
  } ctl_s;

  typedef struct packed {
    logic                   fault;
    fault_cause_e           cause;
    logic [PAGE_ADDR_W-1:0] page_addr;
    logic                   guest_physical_address;
    logic                   memtype_valid;
    logic [2:0]             memtype_index;
    logic                   writeback;
    logic [63:0]            wb_entry;
  } resp_s;

  // Any reserved bit from 51 down to the host address width set
  function automatic logic rsvd_nonzero(input logic [63:0] e);
    return |e[ADDR_TOP:HOST_ADDRESS_WIDTH];
  endfunction : rsvd_nonzero

endpackage : pte4k_pkg

// ### design/pte4k_perm.sv
// Combinational presence, reserved-bit and permission check for one leaf entry.
// Assumes request and control bits are stable while the caller samples the result.
`timescale 1ns/1ns
module pte4k_perm (
  // Request and governing control
  input  wire pte4k_pkg::req_s         req,
  input  wire pte4k_pkg::ctl_s         ctl,
  // Verdict
  output pte4k_pkg::fault_cause_e      cause
);

  logic [63:0] e;

  always_comb begin
    e = req.entry;
    if (!e[pte4k_pkg::PRESENT_BIT]) begin
      cause = pte4k_pkg::CAUSE_NOT_PRESENT;
    end else if (pte4k_pkg::rsvd_nonzero(e)) begin
      cause = pte4k_pkg::CAUSE_RESERVED;
    end else if (req.user && !e[pte4k_pkg::USER_BIT]) begin
      cause = pte4k_pkg::CAUSE_USER;
    end else if (req.write && !e[pte4k_pkg::READ_WRITE_BIT]
                 && (req.user || ctl.write_protect_enable)) begin
      cause = pte4k_pkg::CAUSE_WRITE;
    end else if (req.exec && ctl.no_execute_enable
                 && e[pte4k_pkg::EXECUTE_DISABLE_BIT]) begin
      cause = pte4k_pkg::CAUSE_EXECUTE;
    end else begin
      cause = pte4k_pkg::CAUSE_NONE;
    end
  end

endmodule : pte4k_perm

// ### design/first_level_pte_4k_decode.sv
// Decode and permission check of a first-level leaf entry mapping a 4-KByte page.
// Assumes the page walker holds req and ctl valid while req_valid is high.
`timescale 1ns/1ns
module first_level_pte_4k_decode (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // Request from the walker
  input  wire logic              req_valid,
  input  wire pte4k_pkg::req_s   req,
  input  wire pte4k_pkg::ctl_s   ctl,
  output logic                   req_ready,
  // Result
  output logic                   resp_valid,
  output pte4k_pkg::resp_s       resp
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHECK,
    ST_DONE
  } state_e;

  state_e               state_reg;
  state_e               state_next;
  pte4k_pkg::req_s      req_reg;
  pte4k_pkg::req_s      req_next;
  pte4k_pkg::ctl_s      ctl_reg;
  pte4k_pkg::ctl_s      ctl_next;
  pte4k_pkg::resp_s     resp_reg;
  pte4k_pkg::resp_s     resp_next;
  logic                 ready_reg;
  logic                 ready_next;
  logic                 valid_reg;
  logic                 valid_next;
  pte4k_pkg::fault_cause_e cause;
  logic [63:0]          upd_entry;
  logic [63:0]          e;

  pte4k_perm u_perm (
    .req   (req_reg),
    .ctl   (ctl_reg),
    .cause (cause)
  );

  // Flag updates go out as a new entry image; the walker writes it back.
  // Ignored bits 62:52, 11, 9 and the global bit are passed through untouched.
  always_comb begin
    e         = req_reg.entry;
    upd_entry = e;
    upd_entry[pte4k_pkg::ACCESSED_BIT] = 1'b1;
    if (req_reg.write) begin
      upd_entry[pte4k_pkg::DIRTY_BIT] = 1'b1;
    end
    if (ctl_reg.extended_access_flag_enable) begin
      upd_entry[pte4k_pkg::EXTENDED_ACCESSED_BIT] = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    ctl_next   = ctl_reg;
    resp_next  = resp_reg;
    ready_next = ready_reg;
    valid_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid && ready_reg) begin
          req_next   = req;
          ctl_next   = ctl;
          ready_next = 1'b0;
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        resp_next.cause = cause;
        resp_next.fault = (cause != pte4k_pkg::CAUSE_NONE);
        resp_next.page_addr =
          e[pte4k_pkg::HOST_ADDRESS_WIDTH-1:pte4k_pkg::PAGE_SHIFT];
        resp_next.guest_physical_address =
          (ctl_reg.translation_type_field == pte4k_pkg::TT_NESTED);
        resp_next.memtype_valid = ctl_reg.coherent;
        resp_next.memtype_index = ctl_reg.coherent ?
          {e[pte4k_pkg::PAGE_ATTRIBUTE_BIT], e[pte4k_pkg::CACHE_DISABLE_BIT],
           e[pte4k_pkg::WRITE_THROUGH_BIT]} : pte4k_pkg::MEMTYPE_RESET;
        // A faulting request marks nothing as used
        resp_next.writeback = (cause == pte4k_pkg::CAUSE_NONE)
                              && (upd_entry != e);
        resp_next.wb_entry  = (cause == pte4k_pkg::CAUSE_NONE) ? upd_entry : e;
        valid_next = 1'b1;
        state_next = ST_DONE;
      end
      ST_DONE: begin
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      req_reg   <= '0;
      ctl_reg   <= '0;
      resp_reg  <= '0;
      ready_reg <= 1'b1;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      ctl_reg   <= ctl_next;
      resp_reg  <= resp_next;
      ready_reg <= ready_next;
      valid_reg <= valid_next;
    end
  end

  assign req_ready  = ready_reg;
  assign resp_valid = valid_reg;
  assign resp       = resp_reg;

  // Checks tie each answer to the entry and request taken two cycles earlier
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  logic taken;
  assign taken = req_valid && req_ready;

  AST_RESP_TIMING: assert property (taken |=> !resp_valid ##1 resp_valid ##1 !resp_valid)
    else $error("Answer not two cycles after take");

  AST_EXEC_DENY: assert property (
    taken && req.exec && ctl.no_execute_enable && req.entry[63] && req.entry[0]
    && !pte4k_pkg::rsvd_nonzero(req.entry) |=> ##1 resp.fault)
    else $error("Execute-disabled page was translated");

  AST_PAGE_ADDR: assert property (taken |=> ##1
    resp.page_addr == $past(req.entry[47:12], 2))
    else $error("Page base not taken from entry");

  AST_NESTED: assert property (taken |=> ##1
    resp.guest_physical_address == ($past(ctl.translation_type_field, 2) == 3'h3))
    else $error("Nested flag wrong");

  AST_EA_IGNORED: assert property (resp_valid && !ctl_reg.extended_access_flag_enable
    |-> resp.wb_entry[10] == req_reg.entry[10])
    else $error("Extended-accessed bit changed while disabled");

  AST_IGNORED_KEPT: assert property (resp_valid |->
    resp.wb_entry[62:52] == req_reg.entry[62:52] && resp.wb_entry[11] == req_reg.entry[11]
    && resp.wb_entry[9:8] == req_reg.entry[9:8])
    else $error("Ignored bits altered");

  AST_DIRTY: assert property (resp_valid && !resp.fault && req_reg.write
    |-> resp.wb_entry[6])
    else $error("Dirty not set on write");

  AST_ACCESSED: assert property (resp_valid && !resp.fault |-> resp.wb_entry[5])
    else $error("Accessed not set");

  AST_MEMTYPE: assert property (resp_valid && !ctl_reg.coherent
    |-> !resp.memtype_valid && resp.memtype_index == 3'h0)
    else $error("Memory type used for non-coherent device");

  AST_USER: assert property (taken && req.user && !req.entry[2] |=> ##1 resp.fault)
    else $error("User request allowed to supervisor page");

  AST_WRITE: assert property (taken && req.write && !req.entry[1]
    && (req.user || ctl.write_protect_enable) |=> ##1 resp.fault)
    else $error("Write allowed to read-only page");

  AST_PRESENT: assert property (resp_valid && !req_reg.entry[0]
    |-> resp.fault && !resp.writeback)
    else $error("Non-present entry translated");

  AST_RESERVED: assert property (resp_valid && req_reg.entry[0]
    && pte4k_pkg::rsvd_nonzero(req_reg.entry) |-> resp.cause == pte4k_pkg::CAUSE_RESERVED)
    else $error("Reserved bits not faulted");

  COV_OK_WRITE: cover property (resp_valid && !resp.fault && req_reg.write);
  COV_EXEC_FAULT: cover property (resp_valid && resp.cause == pte4k_pkg::CAUSE_EXECUTE);
  COV_NESTED: cover property (resp_valid && resp.guest_physical_address);
  COV_BACK2BACK: cover property (resp_valid ##3 resp_valid);

endmodule : first_level_pte_4k_decode

// ### verif/pte_walker_model.sv
// Page walker model: presents one leaf entry at a time to the decoder.
// Assumes the decoder takes a request on a rising edge with req_ready high.
`timescale 1ns/1ns
module pte_walker_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Request towards the decoder
  output logic             req_valid,
  output pte4k_pkg::req_s  req,
  output pte4k_pkg::ctl_s  ctl,
  input  wire logic        req_ready
);
  initial begin
    req_valid = 1'b0;
    req = '0;
    ctl = '0;
  end

  // Entries come from the bench table, which sets the present bit for valid mappings
  task automatic issue(input pte4k_pkg::req_s r, input pte4k_pkg::ctl_s c);
    @(negedge clock);
    req_valid = 1'b1;
    req = r;
    ctl = c;
    @(posedge clock);
    while (req_ready !== 1'b1 || resetn !== 1'b1) @(posedge clock);
    @(negedge clock);
    req_valid = 1'b0;
    // Released lines show junk so a stale entry cannot pass for a fresh one
    req = ~r;
    ctl = ~c;
  endtask : issue
endmodule : pte_walker_model

// ### verif/tb_top.sv
// Self-checking bench for the 4-KByte leaf entry decoder.
// Assumes the walker model drives requests; inputs change at falling edges.
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [63:0] entry;
    logic [2:0]  uwx;
    logic [6:0]  ctl;
    logic [2:0]  cause;
  } row_s;
  logic              clock = 1'b0;
  logic              resetn = 1'b0;
  logic              req_valid;
  logic              req_ready;
  logic              resp_valid;
  pte4k_pkg::req_s   req;
  pte4k_pkg::ctl_s   ctl;
  pte4k_pkg::resp_s  resp;
  int                errors = 0;
  int                tests_run = 0;
  // Entry, user/write/exec, 7-bit control field, expected cause
  row_s              rows [16] = '{
    {64'h0000_1234_5678_9001, 3'h0, 7'h00, 3'h0},
    {64'h0000_1234_5678_9000, 3'h0, 7'h00, 3'h1},
    {64'h0001_0000_0000_0001, 3'h0, 7'h00, 3'h2},
    {64'h0008_0000_0000_0001, 3'h0, 7'h00, 3'h2},
    {64'h0008_0000_0000_0000, 3'h0, 7'h00, 3'h1},
    {64'h0000_0000_0000_0003, 3'h4, 7'h00, 3'h3},
    {64'h0000_0000_0000_0005, 3'h6, 7'h00, 3'h4},
    {64'h0000_0000_0000_0005, 3'h2, 7'h00, 3'h0},
    {64'h0000_0000_0000_0005, 3'h2, 7'h20, 3'h4},
    {64'h0000_0000_0000_0007, 3'h6, 7'h20, 3'h0},
    {64'h8000_0000_0000_0001, 3'h1, 7'h40, 3'h5},
    {64'h8000_0000_0000_0001, 3'h1, 7'h00, 3'h0},
    {64'h7FF0_0000_0000_0B01, 3'h0, 7'h17, 3'h0},
    {64'h0000_0000_0000_0099, 3'h0, 7'h01, 3'h0},
    {64'h0000_0000_0000_0099, 3'h0, 7'h04, 3'h0},
    {64'h8000_0000_0000_0001, 3'h5, 7'h40, 3'h3}};

  always #20 clock = ~clock;

  pte_walker_model i_walker (.clock(clock), .resetn(resetn), .req_valid(req_valid),
    .req(req), .ctl(ctl), .req_ready(req_ready));
  first_level_pte_4k_decode i_dut (.clock(clock), .resetn(resetn), .req_valid(req_valid),
    .req(req), .ctl(ctl), .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp));

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cause(input pte4k_pkg::fault_cause_e got, input logic [2:0] exp);
    tests_run++;
    if (got !== pte4k_pkg::fault_cause_e'(exp)) begin
      errors++;
      $display("[ERR] %0t cause %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cause

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic run(input row_s r);
    int              n;
    logic            f;
    pte4k_pkg::ctl_s c;
    logic [63:0]     w;
    n = 0;
    c = r.ctl;
    f = (r.cause != 3'h0);
    w = f ? r.entry : r.entry | 64'h20 | {r.uwx[1], 6'h0}
      | {c.extended_access_flag_enable, 10'h0};
    i_walker.issue({r.entry, r.uwx}, c);
    chk_val(req_ready, 1'b0);
    while (resp_valid !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    chk_val(n, 1);
    chk_cause(resp.cause, r.cause);
    chk_val(resp.fault, f);
    chk_val(resp.page_addr, r.entry[47:12]);
    chk_val(resp.guest_physical_address, c.translation_type_field == pte4k_pkg::TT_NESTED);
    chk_val({resp.memtype_valid, resp.memtype_index},
      c.coherent ? {1'b1, r.entry[7], r.entry[4], r.entry[3]} : 4'h0);
    chk_val(resp.wb_entry, w);
    chk_val(resp.writeback, !f && (w != r.entry));
  endtask : run

  // Roughly 68 cycles are expected; 2000 cycles, about 29 times that, means a hang
  initial begin
    #80000;
    errors++;
    give_verdict();
  end

  initial begin
    repeat (16) @(negedge clock);
    chk_val({req_ready, resp_valid, resp === '0}, 3'h5);
    resetn = 1'b1;
    foreach (rows[i]) run(rows[i]);
    // Reset in mid-run clears the held answer
    resetn = 1'b0;
    @(negedge clock);
    chk_val({req_ready, resp_valid, resp === '0}, 3'h5);
    resetn = 1'b1;
    run(rows[10]);
    give_verdict();
  end
endmodule : tb_top
